// ### rtl/jir_defs.svh
// Summary of operation
// - pin block cells: input, output, enable last
// - input-only pins add one input cell
// - boundary length and order never design-dependent
// - instruction scan captures pattern, shifts LSB first
// - instruction register exactly six bits, [5:0]
// - decode boundary test, sample/preload, bypass
// - decode transceiver pulse and train tests
// - decode user registers a and b
// - decode user registers c and d
// - decode user code and identification shifts
// - float user pins, scan through bypass
// - decode configuration load and readback access
// - decode reprogram, startup step, shutdown step
// - decode monitor port, no-op; others reserved
// - capture pattern: done, init, active, finished, 01
// - bypass flop, loads zero at capture
// - 32-bit identification, least bit one
// - 32-bit configuration access register
// - user code all ones when blank
// - user registers exist only after configuration
// - five mode-high clocks reach reset state
// - opcode latched on falling edge in update
`ifndef JIR_DEFS_SVH
`define JIR_DEFS_SVH
`define JIR_IR_W 6
`define JIR_DR_W 32
`define JIR_OP_EXTEST 6'h26
`define JIR_OP_PULSE 6'h3C
`define JIR_OP_TRAIN 6'h3D
`define JIR_OP_SAMPLE 6'h01
`define JIR_OP_USER_A 6'h02
`define JIR_OP_USER_B 6'h03
`define JIR_OP_USER_C 6'h22
`define JIR_OP_USER_D 6'h23
`define JIR_OP_DESIGN_USER_CODE 6'h08
`define JIR_OP_DEVICE_IDENTIFICATION 6'h09
`define JIR_OP_FLOAT 6'h0A
`define JIR_OP_BYPASS 6'h3F
`define JIR_OP_CFG_WR 6'h05
`define JIR_OP_CFG_RD 6'h04
`define JIR_OP_REPROG 6'h0B
`define JIR_OP_START 6'h0C
`define JIR_OP_SHUT 6'h0D
`define JIR_OP_MONITOR 6'h37
`define JIR_OP_NOOP 6'h14
`define JIR_CAPTURE_LOW 2'h1
`define JIR_DESIGN_USER_CODE_BLANK 32'hFFFFFFFF
`define JIR_DEVICE_IDENTIFICATION_DEFAULT 32'h12345001
`define JIR_BND_PINS 4
`define JIR_BND_INPINS 2
`define JIR_BND_LEN 14
`endif

// ### rtl/jir_pkg.sv
package jir_pkg;
  typedef enum logic [3:0] {
    TEST_RESET, RUN_IDLE, SEL_DR, CAP_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPD_DR,
    SEL_IR, CAP_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPD_IR
  } jir_tap_t;
  typedef enum logic [3:0] {
    SEL_BOUNDARY, SEL_BYPASS, SEL_DEVICE_IDENTIFICATION, SEL_DESIGN_USER_CODE, SEL_CONFIG, SEL_USER, SEL_MONITOR
  } jir_path_t;
endpackage : jir_pkg

// ### rtl/jir_test_port.sv
`timescale 1ns/100ps
`include "jir_defs.svh"
module jir_test_port #(
  parameter logic [31:0] ID_CODE = `JIR_DEVICE_IDENTIFICATION_DEFAULT // arbitrary value, lsb kept 1
) (
  input wire logic tck,
  input wire logic rstn,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdoEnable,
  input wire logic clock,
  input wire logic configDone,
  input wire logic initStatus,
  input wire logic insysConfigActiveFlag,
  input wire logic insysConfigFinishedFlag,
  input wire logic [31:0] designUserCode,
  input wire logic userCodeValid,
  input wire logic [31:0] configReadData,
  output logic [31:0] configWriteData,
  output logic configWriteStrobe,
  output logic configReadActive,
  input wire logic [`JIR_BND_PINS-1:0] pinIn,
  input wire logic [`JIR_BND_INPINS-1:0] inputOnlyPinIn,
  output logic [`JIR_BND_PINS-1:0] pinOut,
  output logic [`JIR_BND_PINS-1:0] pinOutEnable,
  output logic boundaryDrive,
  output logic floatUserPins,
  output logic reprogramReq,
  output logic startupStep,
  output logic shutdownStep,
  output logic userSelect,
  output logic [1:0] userIndex,
  output logic userCapture,
  output logic userShift,
  output logic userUpdate,
  input wire logic userTdo,
  output logic monitorSelect,
  input wire logic monitorTdo,
  output logic [5:0] activeOpcode
);
  jir_pkg::jir_tap_t tapState;
  jir_pkg::jir_tap_t next_tapState;
  logic [5:0] instructionShift;
  logic bypassFlop;
  logic [31:0] dataShift;
  logic [`JIR_BND_LEN-1:0] boundaryShift;
  logic [`JIR_BND_LEN-1:0] boundaryUpdate;
  logic [1:0] configSync;
  logic [1:0] initSync;
  logic [1:0] activeSync;
  logic [1:0] finishedSync;
  logic [1:0] userValidSync;
  logic [1:0] cfgWrSync;
  logic cfgWrToggle;
  logic cfgWrSeen;
  logic [31:0] cfgWrWord;
  logic [4:0] cfgCount;
  jir_pkg::jir_path_t path;
  logic tdoNext;

  function automatic jir_pkg::jir_path_t decodePath(input logic [5:0] op);
    case (op)
      `JIR_OP_EXTEST, `JIR_OP_SAMPLE, `JIR_OP_PULSE, `JIR_OP_TRAIN: decodePath = jir_pkg::SEL_BOUNDARY;
      `JIR_OP_USER_A, `JIR_OP_USER_B: decodePath = jir_pkg::SEL_USER;
      `JIR_OP_USER_C, `JIR_OP_USER_D: decodePath = jir_pkg::SEL_USER;
      `JIR_OP_DESIGN_USER_CODE: decodePath = jir_pkg::SEL_DESIGN_USER_CODE;
      `JIR_OP_DEVICE_IDENTIFICATION: decodePath = jir_pkg::SEL_DEVICE_IDENTIFICATION;
      `JIR_OP_CFG_WR, `JIR_OP_CFG_RD: decodePath = jir_pkg::SEL_CONFIG;
      `JIR_OP_MONITOR: decodePath = jir_pkg::SEL_MONITOR;
      default: decodePath = jir_pkg::SEL_BYPASS;
    endcase
  endfunction : decodePath

  // status flags come from the configuration clock domain
  always_ff @(posedge tck or negedge rstn) begin
    if (!rstn) begin
      configSync <= 2'h0;
      initSync <= 2'h0;
      activeSync <= 2'h0;
      finishedSync <= 2'h0;
      userValidSync <= 2'h0;
    end else begin
      configSync <= {configSync[0], configDone};
      initSync <= {initSync[0], initStatus};
      activeSync <= {activeSync[0], insysConfigActiveFlag};
      finishedSync <= {finishedSync[0], insysConfigFinishedFlag};
      userValidSync <= {userValidSync[0], userCodeValid};
    end
  end

  always_comb begin
    next_tapState = tapState;
    case (tapState)
      jir_pkg::TEST_RESET: next_tapState = tms ? jir_pkg::TEST_RESET : jir_pkg::RUN_IDLE;
      jir_pkg::RUN_IDLE: next_tapState = tms ? jir_pkg::SEL_DR : jir_pkg::RUN_IDLE;
      jir_pkg::SEL_DR: next_tapState = tms ? jir_pkg::SEL_IR : jir_pkg::CAP_DR;
      jir_pkg::CAP_DR: next_tapState = tms ? jir_pkg::EXIT1_DR : jir_pkg::SHIFT_DR;
      jir_pkg::SHIFT_DR: next_tapState = tms ? jir_pkg::EXIT1_DR : jir_pkg::SHIFT_DR;
      jir_pkg::EXIT1_DR: next_tapState = tms ? jir_pkg::UPD_DR : jir_pkg::PAUSE_DR;
      jir_pkg::PAUSE_DR: next_tapState = tms ? jir_pkg::EXIT2_DR : jir_pkg::PAUSE_DR;
      jir_pkg::EXIT2_DR: next_tapState = tms ? jir_pkg::UPD_DR : jir_pkg::SHIFT_DR;
      jir_pkg::UPD_DR: next_tapState = tms ? jir_pkg::SEL_DR : jir_pkg::RUN_IDLE;
      jir_pkg::SEL_IR: next_tapState = tms ? jir_pkg::TEST_RESET : jir_pkg::CAP_IR;
      jir_pkg::CAP_IR: next_tapState = tms ? jir_pkg::EXIT1_IR : jir_pkg::SHIFT_IR;
      jir_pkg::SHIFT_IR: next_tapState = tms ? jir_pkg::EXIT1_IR : jir_pkg::SHIFT_IR;
      jir_pkg::EXIT1_IR: next_tapState = tms ? jir_pkg::UPD_IR : jir_pkg::PAUSE_IR;
      jir_pkg::PAUSE_IR: next_tapState = tms ? jir_pkg::EXIT2_IR : jir_pkg::PAUSE_IR;
      jir_pkg::EXIT2_IR: next_tapState = tms ? jir_pkg::UPD_IR : jir_pkg::SHIFT_IR;
      jir_pkg::UPD_IR: next_tapState = tms ? jir_pkg::SEL_DR : jir_pkg::RUN_IDLE;
      default: next_tapState = jir_pkg::TEST_RESET;
    endcase
  end

  always_ff @(posedge tck or negedge rstn) begin
    if (!rstn) begin
      tapState <= jir_pkg::TEST_RESET;
    end else begin
      tapState <= next_tapState;
    end
  end

  always_ff @(posedge tck or negedge rstn) begin
    if (!rstn) begin
      instructionShift <= 6'h00;
    end else if (tapState == jir_pkg::CAP_IR) begin
      instructionShift <= {configSync[1], initSync[1], activeSync[1], finishedSync[1],
                           `JIR_CAPTURE_LOW};
    end else if (tapState == jir_pkg::SHIFT_IR) begin
      instructionShift <= {tdi, instructionShift[5:1]};
    end
  end

  // instruction latch on the falling edge
  always_ff @(negedge tck or negedge rstn) begin
    if (!rstn) begin
      activeOpcode <= `JIR_OP_DEVICE_IDENTIFICATION;
    end else if (tapState == jir_pkg::TEST_RESET) begin
      activeOpcode <= `JIR_OP_DEVICE_IDENTIFICATION;
    end else if (tapState == jir_pkg::UPD_IR) begin
      activeOpcode <= instructionShift;
    end
  end

  // user paths fall back to bypass until configured
  always_comb begin
    path = decodePath(activeOpcode);
    if (path == jir_pkg::SEL_USER && !configSync[1]) begin
      path = jir_pkg::SEL_BYPASS;
    end
  end

  always_ff @(posedge tck or negedge rstn) begin
    if (!rstn) begin
      bypassFlop <= 1'b0;
    end else if (tapState == jir_pkg::CAP_DR) begin
      bypassFlop <= 1'b0;
    end else if (tapState == jir_pkg::SHIFT_DR) begin
      bypassFlop <= tdi;
    end
  end

  // one shift register serves id, user code and configuration paths
  always_ff @(posedge tck or negedge rstn) begin
    if (!rstn) begin
      dataShift <= 32'h00000000;
    end else if (tapState == jir_pkg::CAP_DR) begin
      if (path == jir_pkg::SEL_DEVICE_IDENTIFICATION) begin
        dataShift <= {ID_CODE[31:1], 1'b1};
      end else if (path == jir_pkg::SEL_DESIGN_USER_CODE) begin
        dataShift <= userValidSync[1] ? designUserCode : `JIR_DESIGN_USER_CODE_BLANK;
      end else if (path == jir_pkg::SEL_CONFIG) begin
        dataShift <= configReadData;
      end
    end else if (tapState == jir_pkg::SHIFT_DR) begin
      dataShift <= {tdi, dataShift[31:1]};
    end
  end

  // boundary chain: per pin input, output, enable (enable nearest tdo), then input-only cells
  always_ff @(posedge tck or negedge rstn) begin
    if (!rstn) begin
      boundaryShift <= '0;
    end else if (tapState == jir_pkg::CAP_DR && path == jir_pkg::SEL_BOUNDARY) begin
      for (int i = 0; i < `JIR_BND_INPINS; i++) begin
        boundaryShift[`JIR_BND_LEN-1-i] <= inputOnlyPinIn[i];
      end
      for (int p = 0; p < `JIR_BND_PINS; p++) begin
        boundaryShift[3*p+2] <= pinIn[p];
        boundaryShift[3*p+1] <= pinOut[p];
        boundaryShift[3*p] <= pinOutEnable[p];
      end
    end else if (tapState == jir_pkg::SHIFT_DR && path == jir_pkg::SEL_BOUNDARY) begin
      boundaryShift <= {tdi, boundaryShift[`JIR_BND_LEN-1:1]};
    end
  end

  always_ff @(negedge tck or negedge rstn) begin
    if (!rstn) begin
      boundaryUpdate <= '0;
    end else if (tapState == jir_pkg::UPD_DR && path == jir_pkg::SEL_BOUNDARY) begin
      boundaryUpdate <= boundaryShift;
    end
  end

  always_comb begin
    for (int p = 0; p < `JIR_BND_PINS; p++) begin
      pinOut[p] = boundaryUpdate[3*p+1];
      pinOutEnable[p] = boundaryUpdate[3*p];
    end
  end

  always_comb begin
    case (path)
      jir_pkg::SEL_BOUNDARY: tdoNext = boundaryShift[0];
      jir_pkg::SEL_DEVICE_IDENTIFICATION, jir_pkg::SEL_DESIGN_USER_CODE, jir_pkg::SEL_CONFIG: tdoNext = dataShift[0];
      jir_pkg::SEL_USER: tdoNext = userTdo;
      jir_pkg::SEL_MONITOR: tdoNext = monitorTdo;
      default: tdoNext = bypassFlop;
    endcase
  end

  // tdo changes on the falling edge, per scan convention
  always_ff @(negedge tck or negedge rstn) begin
    if (!rstn) begin
      tdo <= 1'b0;
      tdoEnable <= 1'b0;
    end else begin
      tdo <= (tapState == jir_pkg::SHIFT_IR) ? instructionShift[0] : tdoNext;
      tdoEnable <= (tapState == jir_pkg::SHIFT_IR) || (tapState == jir_pkg::SHIFT_DR);
    end
  end

  always_ff @(posedge tck or negedge rstn) begin
    if (!rstn) begin
      boundaryDrive <= 1'b0;
      floatUserPins <= 1'b0;
      reprogramReq <= 1'b0;
      monitorSelect <= 1'b0;
      userSelect <= 1'b0;
      userIndex <= 2'h0;
      configReadActive <= 1'b0;
    end else begin
      boundaryDrive <= activeOpcode == `JIR_OP_EXTEST || activeOpcode == `JIR_OP_PULSE
                       || activeOpcode == `JIR_OP_TRAIN;
      floatUserPins <= activeOpcode == `JIR_OP_FLOAT;
      reprogramReq <= activeOpcode == `JIR_OP_REPROG;
      monitorSelect <= activeOpcode == `JIR_OP_MONITOR;
      userSelect <= path == jir_pkg::SEL_USER;
      userIndex <= {activeOpcode[5], activeOpcode[0]};
      configReadActive <= activeOpcode == `JIR_OP_CFG_RD;
    end
  end

  always_comb begin
    userCapture = userSelect && tapState == jir_pkg::CAP_DR;
    userShift = userSelect && tapState == jir_pkg::SHIFT_DR;
    userUpdate = userSelect && tapState == jir_pkg::UPD_DR;
  end

  // startup and shutdown stepped once per run-idle clock
  always_ff @(posedge tck or negedge rstn) begin
    if (!rstn) begin
      startupStep <= 1'b0;
      shutdownStep <= 1'b0;
    end else begin
      startupStep <= tapState == jir_pkg::RUN_IDLE && activeOpcode == `JIR_OP_START;
      shutdownStep <= tapState == jir_pkg::RUN_IDLE && activeOpcode == `JIR_OP_SHUT;
    end
  end

  // configuration words collected in tck domain, handed over by toggle
  always_ff @(posedge tck or negedge rstn) begin
    if (!rstn) begin
      cfgCount <= 5'h00;
      cfgWrToggle <= 1'b0;
      cfgWrWord <= 32'h00000000;
    end else if (tapState == jir_pkg::SHIFT_DR && activeOpcode == `JIR_OP_CFG_WR) begin
      cfgCount <= cfgCount + 5'h01;
      if (cfgCount == 5'h1F) begin
        cfgWrWord <= {tdi, dataShift[31:1]};
        cfgWrToggle <= ~cfgWrToggle;
      end
    end else if (tapState != jir_pkg::SHIFT_DR) begin
      cfgCount <= 5'h00;
    end
  end

  // word held stable for a full frame, so sampling it after the toggle is safe
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cfgWrSync <= 2'h0;
      cfgWrSeen <= 1'b0;
      configWriteStrobe <= 1'b0;
      configWriteData <= 32'h00000000;
    end else begin
      cfgWrSync <= {cfgWrSync[0], cfgWrToggle};
      cfgWrSeen <= cfgWrSync[1];
      configWriteStrobe <= cfgWrSync[1] ^ cfgWrSeen;
      if (cfgWrSync[1] ^ cfgWrSeen) begin
        configWriteData <= cfgWrWord;
      end
    end
  end
endmodule : jir_test_port

// ### testbench/jir_test_port_monitor.sv
`timescale 1ns/100ps
module jir_port_monitor (
  input wire logic tck,
  input wire logic rstn,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo,
  input wire logic tdoEnable,
  input wire logic boundaryDrive,
  input wire logic floatUserPins,
  input wire logic reprogramReq,
  input wire logic userSelect,
  input wire logic [1:0] userIndex,
  input wire logic monitorSelect,
  input wire logic [5:0] activeOpcode
);
  // next tap state, nibble i for state i
  localparam logic [63:0] NEXT0 = 64'h1BDDBBA146644311;
  localparam logic [63:0] NEXT1 = 64'h2FEFCC0287855920;
  logic [3:0] tapState;
  logic [5:0] lastOp;
  logic [5:0] instrSeen;
  logic [2:0] instrCount;
  logic viaBypass;
  assign viaBypass = (activeOpcode inside {6'h3F, 6'h0A}) || !(activeOpcode inside {6'h26,
    6'h3C, 6'h3D, 6'h01, 6'h02, 6'h03, 6'h22, 6'h23, 6'h08, 6'h09, 6'h05, 6'h04, 6'h0B,
    6'h0C, 6'h0D, 6'h37, 6'h14});
  // lastOp instead of $past: survives a reset without stale history
  always_ff @(posedge tck or negedge rstn) begin
    if (!rstn) begin
      tapState <= 4'h0;
      lastOp <= 6'h09;
    end else begin
      tapState <= tms ? NEXT1[{tapState, 2'b00} +: 4] : NEXT0[{tapState, 2'b00} +: 4];
      lastOp <= activeOpcode;
    end
  end
  // short scans mix in capture bits, so only full six-bit scans are judged
  always_ff @(posedge tck or negedge rstn) begin
    if (!rstn) begin
      instrSeen <= 6'h00;
      instrCount <= 3'h0;
    end else if (tapState == 4'hA) begin
      instrCount <= 3'h0;
    end else if (tapState == 4'hB) begin
      instrSeen <= {tdi, instrSeen[5:1]};
      instrCount <= (instrCount == 3'h6) ? instrCount : instrCount + 3'h1;
    end
  end
  default clocking cb @(posedge tck); endclocking
  default disable iff (!rstn);
  property p_tms_reset; tms [*5] |=> activeOpcode == 6'h09; endproperty
  a_tms_reset: assert property (p_tms_reset) else $error("mode-high run kept op");
  property p_shift_en; tdoEnable == (tapState inside {4'h4, 4'hB}); endproperty
  a_shift_en: assert property (p_shift_en) else $error("serial out enable wrong");
  property p_capture; (tapState == 4'hA) ##1 (tapState == 4'hB && !tms) |-> tdo ##1 !tdo; endproperty
  a_capture: assert property (p_capture) else $error("capture low bits wrong");
  property p_update; tapState == 4'hF && instrCount == 3'h6 |-> activeOpcode == instrSeen; endproperty
  a_update: assert property (p_update) else $error("opcode not latched");
  property p_bypass; tapState == 4'h4 && viaBypass && ($past(tapState) inside {4'h3, 4'h4})
    |-> tdo == (($past(tapState) == 4'h3) ? 1'b0 : $past(tdi)); endproperty
  a_bypass: assert property (p_bypass) else $error("single flop path wrong");
  property p_drive; boundaryDrive == (lastOp inside {6'h26, 6'h3C, 6'h3D}); endproperty
  a_drive: assert property (p_drive) else $error("pin drive mode wrong");
  property p_float; floatUserPins == (lastOp == 6'h0A); endproperty
  a_float: assert property (p_float) else $error("float mode wrong");
  property p_reprog; reprogramReq == (lastOp == 6'h0B); endproperty
  a_reprog: assert property (p_reprog) else $error("reprogram request wrong");
  property p_monitor; monitorSelect == (lastOp == 6'h37); endproperty
  a_monitor: assert property (p_monitor) else $error("monitor select wrong");
  property p_user; userSelect |-> (lastOp inside {6'h02, 6'h03, 6'h22, 6'h23})
    && userIndex == {lastOp[5], lastOp[0]}; endproperty
  a_user: assert property (p_user) else $error("user select wrong");
  c_shift: cover property (tapState == 4'hB);
  c_bypass: cover property (tapState == 4'h4 && viaBypass);
  c_user: cover property (userSelect);
endmodule : jir_port_monitor
bind jir_test_port jir_port_monitor monitor (.tck, .rstn, .tms, .tdi, .tdo, .tdoEnable,
  .boundaryDrive, .floatUserPins, .reprogramReq, .userSelect, .userIndex, .monitorSelect,
  .activeOpcode);

// ### testbench/jir_jtag_host.sv
`timescale 1ns/100ps
module jir_jtag_host (
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  // tck parked low outside frames; tdi rests at its pull-up level
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #3 tck = 1'b1;
    q = tdo;
    #3 tck = 1'b0;
  endtask : step
  task automatic idle(input int n);
    logic q;
    repeat (n) step(1'b0, 1'b1, q);
  endtask : idle
  task automatic reset5;
    logic q;
    repeat (5) step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
  endtask : reset5
  // starts and ends in run-idle
  task automatic scan(input logic isInstr, input int n, input logic [31:0] din,
    output logic [31:0] dout);
    logic q;
    dout = 32'h00000000;
    step(1'b1, 1'b1, q);
    if (isInstr) step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
    step(1'b0, 1'b1, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
  endtask : scan
endmodule : jir_jtag_host

// ### testbench/testbench.sv
`timescale 1ns/100ps
module testbench;
  localparam logic [31:0] TB_ID = 32'h13579BDF; // arbitrary value, lsb one
  localparam logic [31:0] PAT = 32'h9E376A4D;
  localparam logic [5:0] OPS [21] = '{6'h26, 6'h3C, 6'h3D, 6'h01, 6'h02, 6'h03, 6'h22, 6'h23,
    6'h08, 6'h09, 6'h0A, 6'h3F, 6'h05, 6'h04, 6'h0B, 6'h0C, 6'h0D, 6'h37, 6'h14, 6'h15, 6'h3E};
  logic clock, rstn, tck, tms, tdi, tdo, tdoEnable, configDone, initStatus, userCodeValid;
  logic insysConfigActiveFlag, insysConfigFinishedFlag, configWriteStrobe, configReadActive;
  logic boundaryDrive, floatUserPins, reprogramReq, startupStep, shutdownStep, userSelect;
  logic userCapture, userShift, userUpdate, userTdo, monitorSelect, monitorTdo;
  logic [1:0] userIndex, inputOnlyPinIn;
  logic [3:0] pinIn, pinOut, pinOutEnable;
  logic [5:0] activeOpcode;
  logic [31:0] designUserCode, configReadData, configWriteData, dout;
  int mismatches, samples_checked, cycles, strobes, wantStrobes, runSteps, userShifts;
  jir_test_port #(.ID_CODE(TB_ID)) uut (.tck, .rstn, .tms, .tdi, .tdo, .tdoEnable, .clock,
    .configDone, .initStatus, .insysConfigActiveFlag, .insysConfigFinishedFlag,
    .designUserCode, .userCodeValid, .configReadData, .configWriteData, .configWriteStrobe,
    .configReadActive, .pinIn, .inputOnlyPinIn, .pinOut, .pinOutEnable, .boundaryDrive,
    .floatUserPins, .reprogramReq, .startupStep, .shutdownStep, .userSelect, .userIndex,
    .userCapture, .userShift, .userUpdate, .userTdo, .monitorSelect, .monitorTdo, .activeOpcode);
  jir_jtag_host host (.tck, .tms, .tdi, .tdo);
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // counted off the falling edge, opposite the launching edge, so the pulse is settled
  always @(negedge clock) strobes += configWriteStrobe;
  always @(negedge tck) runSteps += startupStep | shutdownStep;
  always @(negedge tck) userShifts += userShift;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // status inputs cross on tck, so idle edges let them settle
  task automatic setIn(input logic [3:0] f, input logic v);
    @(negedge clock);
    {configDone, initStatus, insysConfigActiveFlag, insysConfigFinishedFlag} = f;
    userCodeValid = v;
    host.idle(4);
  endtask : setIn
  task automatic runOp(input logic [5:0] op, input logic cfg);
    int n0, u0;
    host.scan(1'b1, 6, {26'h0, op}, dout);
    chk(activeOpcode, op);
    n0 = runSteps;
    u0 = userShifts;
    host.scan(1'b0, 32, PAT, dout);
    case (op)
      6'h09: chk(dout, TB_ID);
      6'h08: chk(dout, cfg ? designUserCode : 32'hFFFFFFFF);
      6'h04: begin
        chk(dout, configReadData);
        chk(configReadActive, 1'b1);
      end
      6'h05: begin
        wantStrobes++;
        repeat (10) @(negedge clock);
        chk(strobes, wantStrobes);
        chk(configWriteData, PAT);
      end
      6'h01, 6'h26, 6'h3C, 6'h3D: begin
        chk(dout[31:14], PAT[17:0]);
        chk({dout[12], dout[13], dout[11], dout[8], dout[5], dout[2]}, {inputOnlyPinIn, pinIn});
        chk(boundaryDrive, op != 6'h01);
        chk({pinOut, pinOutEnable}, {PAT[28], PAT[25], PAT[22], PAT[19], PAT[27], PAT[24],
          PAT[21], PAT[18]});
      end
      6'h3F, 6'h0A, 6'h14, 6'h15, 6'h3E: chk(dout, {PAT[30:0], 1'b0});
      6'h02, 6'h03, 6'h22, 6'h23: begin
        chk(userSelect, cfg);
        chk(userShifts - u0, cfg ? 32 : 0);
        if (cfg) chk(userIndex, {op[5], op[0]});
        if (!cfg) chk(dout, {PAT[30:0], 1'b0});
      end
      6'h37: chk(monitorSelect, 1'b1);
      6'h0B: chk(reprogramReq, 1'b1);
      6'h0C, 6'h0D: begin
        host.idle(3);
        chk(runSteps - n0 >= 2, 1'b1);
      end
      default: ;
    endcase
  endtask : runOp
  task tally_and_finish;
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    rstn = 1'b0;
    {configDone, initStatus, insysConfigActiveFlag, insysConfigFinishedFlag} = 4'h0;
    {userCodeValid, userTdo, monitorTdo} = 3'h0;
    {pinIn, inputOnlyPinIn} = 6'h29;
    designUserCode = 32'hC0DE0042;
    configReadData = 32'h5A0F3C96;
    repeat (3) @(posedge clock);
    @(negedge clock);
    rstn = 1'b1;
    host.reset5();
    chk(activeOpcode, 6'h09);
    host.scan(1'b0, 32, PAT, dout);
    chk(dout, TB_ID);
    for (int k = 0; k < 2; k++) begin
      setIn(k ? 4'h5 : 4'hA, 1'b0);
      host.scan(1'b1, 6, 32'h0000003F, dout);
      chk(dout[5:0], {k ? 4'h5 : 4'hA, 2'b01});
    end
    for (int p = 0; p < 2; p++) begin
      setIn({p[0], 3'b000}, p[0]);
      for (int i = 0; i < 21; i++) runOp(OPS[i], p[0]);
    end
    host.scan(1'b1, 6, 32'h0000003F, dout);
    host.reset5();
    chk(activeOpcode, 6'h09);
    host.scan(1'b1, 6, 32'h0000000A, dout);
    @(negedge clock);
    rstn = 1'b0;
    @(negedge clock);
    chk(activeOpcode, 6'h09);
    rstn = 1'b1;
    host.reset5();
    tally_and_finish();
  end
endmodule : testbench
